// File: sim/sep_master.sv
// Purpose: link master model for the serial eeprom port
// Assumes: serial clock idles low, 2 clk high and 6 clk low per bit
// Notes: stall lengthens the low phase to halt the serial clock
`timescale 1ns/10ps
module sep_master (
	input  wire logic clk,
	output logic      selectN,
	output logic      serialClk,
	output logic      serialIn,
	input  wire logic serialOut,
	input  wire logic serialOutEn
);
	int stall;
	initial
	begin
		selectN = 1'b1;
		serialClk = 1'b0;
		serialIn = 1'b0;
		stall = 0;
	end
	task automatic wait_clk(input int n);
		repeat (n) @(negedge clk);
	endtask : wait_clk
	task automatic open_frame();
		wait_clk(2);
		selectN = 1'b0;
		wait_clk(2);
	endtask : open_frame
	// output bit read late in the low phase, after it has settled
	task automatic shift(input int n, input logic [7:0] tx, output logic [7:0] rx);
		rx = 8'h00;
		for (int i = 7; i > 7 - n; i--)
		begin
			serialIn = tx[i];
			wait_clk(6 + stall);
			rx[i] = serialOutEn ? serialOut : 1'bx;
			serialClk = 1'b1;
			wait_clk(2);
			serialClk = 1'b0;
		end
	endtask : shift
	// released data line shows the inverse of its last bit
	task automatic close_frame();
		wait_clk(2);
		selectN = 1'b1;
		serialIn = ~serialIn;
		wait_clk(4);
	endtask : close_frame
endmodule : sep_master

// File: sim/spi_eeprom_command_port_bench.sv
// Purpose: self-checking bench for the serial eeprom command port
// Assumes: short internal write so a run stays brief
// Notes: array bytes are compared only where the bench has written them
`timescale 1ns/10ps
module spi_eeprom_command_port_bench;
	import sep_pkg::*;
	localparam int WCYC = 400;
	logic       clk, rstn, selectN, serialClk, serialIn, writeProtectN;
	logic       serialOut, serialOutEn, busyWriting;
	logic [1:0] dogPeriod;
	logic [7:0] rx;
	int         fail_count, check_count, latch, lockSel, dogSel, seed;
	int         mem [512];
	always #25 clk = ~clk;
	sep_port #(.WRITE_CYCLES(WCYC)) u_dut (.clk(clk), .rstn(rstn), .selectN(selectN), .serialClk(serialClk),
		.serialIn(serialIn), .writeProtectN(writeProtectN), .serialOut(serialOut), .serialOutEn(serialOutEn),
		.dogPeriod(dogPeriod), .busyWriting(busyWriting));
	sep_master u_master (.clk(clk), .selectN(selectN), .serialClk(serialClk), .serialIn(serialIn),
		.serialOut(serialOut), .serialOutEn(serialOutEn));
	task automatic close_out();
		$display("checks %0d mismatches %0d", check_count, fail_count);
		if (fail_count == 0 && check_count > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask : close_out
	task automatic check(input logic [7:0] got, input logic [7:0] exp, input string what);
		check_count++;
		if (got !== exp)
		begin
			fail_count++;
			$display("wrong value at %0t: %s got %h want %h", $time, what, got, exp);
		end
	endtask : check
	function automatic logic locked(input logic [8:0] a);
		return lockSel == 3 || (lockSel == 2 && a >= SEP_LOCK_HALF) || (lockSel == 1 && a >= SEP_LOCK_QUARTER);
	endfunction : locked
	task automatic cmd1(input logic [7:0] op);
		u_master.open_frame();
		u_master.shift(8, op, rx);
		u_master.close_frame();
		if (op == SEP_OP_SET_LATCH)
			latch = 1;
		if (op == SEP_OP_CLR_LATCH)
			latch = 0;
	endtask : cmd1
	task automatic rd_status(output logic [7:0] v);
		u_master.open_frame();
		u_master.shift(8, SEP_OP_READ_STATUS, rx);
		u_master.shift(8, 8'h00, v);
		u_master.close_frame();
	endtask : rd_status
	task automatic st_check();
		logic [7:0] v;
		rd_status(v);
		check(v, {2'b00, 2'(dogSel), 2'(lockSel), 1'(latch), 1'b0}, "status");
	endtask : st_check
	task automatic wait_write(input int acc);
		int n;
		n = 0;
		repeat (8) @(negedge clk);
		if (acc < 2)
			check({7'h00, busyWriting}, 8'(acc), "busy start");
		while (busyWriting !== 1'b0 && n < WCYC + 100)
		begin
			@(negedge clk);
			n++;
		end
		check({7'h00, busyWriting}, 8'h00, "busy end");
	endtask : wait_write
	task automatic rd_array(input logic [8:0] a, input int n);
		u_master.open_frame();
		u_master.shift(8, {4'h0, a[8], SEP_OP_READ_LOW}, rx);
		u_master.shift(8, a[7:0], rx);
		for (int i = 0; i < n; i++)
		begin
			u_master.shift(8, 8'h00, rx);
			check(rx, 8'(mem[(a + i) % 512]), "array");
		end
		u_master.close_frame();
	endtask : rd_array
	task automatic wr_array(input logic [8:0] a, input int n);
		logic [7:0] d;
		int         acc;
		logic       lk;
		cmd1(SEP_OP_SET_LATCH);
		acc = (writeProtectN === 1'b1) ? latch : 0;
		lk = locked(a);
		u_master.open_frame();
		u_master.shift(8, {4'h0, a[8], SEP_OP_WRITE_LOW}, rx);
		u_master.shift(8, a[7:0], rx);
		for (int i = 0; i < n; i++)
		begin
			d = 8'($urandom);
			u_master.shift(8, d, rx);
			if (acc == 1 && !locked({a[8:4], 4'(a[3:0] + i)}))
				mem[{a[8:4], 4'(a[3:0] + i)}] = d;
		end
		u_master.close_frame();
		latch = 0;
		wait_write(lk ? 2 : acc);
	endtask : wr_array
	task automatic wr_status(input logic [7:0] v);
		logic [7:0] s;
		cmd1(SEP_OP_SET_LATCH);
		u_master.open_frame();
		u_master.shift(8, SEP_OP_WRITE_STAT, rx);
		u_master.shift(8, v, rx);
		u_master.close_frame();
		repeat (8) @(negedge clk);
		rd_status(s);
		check({7'h00, s[0]}, 8'h01, "busy bit");
		dogSel = v[5:4];
		lockSel = v[3:2];
		latch = 0;
		wait_write(2);
		st_check();
		check({6'h00, dogPeriod}, {6'h00, v[5:4]}, "period");
	endtask : wr_status
	// refused status writes: latch clear, or latch set in the same frame
	task automatic raw_wstat(input logic pre);
		u_master.open_frame();
		if (pre)
			u_master.shift(8, SEP_OP_SET_LATCH, rx);
		u_master.shift(8, SEP_OP_WRITE_STAT, rx);
		u_master.shift(8, 8'h3c, rx);
		u_master.close_frame();
		if (pre)
			latch = 1;
		wait_write(0);
		st_check();
	endtask : raw_wstat
	// abandoned write: short last byte, or protect dropped while selected
	task automatic bad_write(input int bits, input logic dropProt);
		cmd1(SEP_OP_SET_LATCH);
		u_master.open_frame();
		u_master.shift(8, {5'h00, SEP_OP_WRITE_LOW}, rx);
		u_master.shift(8, 8'h00, rx);
		u_master.shift(8, 8'($urandom), rx);
		if (bits < 8)
			u_master.shift(bits, 8'($urandom), rx);
		writeProtectN = ~dropProt;
		u_master.close_frame();
		if (dropProt)
			latch = 0;
		wait_write(0);
		writeProtectN = 1'b1;
		rd_array(9'h000, 1);
		st_check();
	endtask : bad_write
	initial
	begin
		#4_000_000;
		fail_count++;
		close_out();
	end
	initial
	begin
		clk = 1'b0;
		rstn = 1'b0;
		writeProtectN = 1'b1;
		fail_count = 0;
		check_count = 0;
		latch = 0;
		lockSel = 0;
		dogSel = 0;
		foreach (mem[i]) mem[i] = -1;
		seed = $urandom(32'h9135_b09c);
		repeat (5) @(negedge clk);
		rstn = 1'b1;
		st_check();
		cmd1(SEP_OP_SET_LATCH);
		st_check();
		cmd1(SEP_OP_CLR_LATCH);
		st_check();
		raw_wstat(1'b0);
		raw_wstat(1'b1);
		for (int k = 3; k >= 0; k--)
			wr_status({2'b00, 2'(k), 4'h0});
		wr_array(9'h1fc, 8);
		wr_array(9'h000, 1);
		u_master.stall = 30;
		rd_array(9'h1fc, 5);
		u_master.stall = 0;
		rd_array(9'h1f0, 4);
		bad_write(4, 1'b0);
		bad_write(8, 1'b1);
		wr_status(8'h08);
		wr_array(9'h1f0, 1);
		wr_array(9'h0f0, 2);
		rd_array(9'h1f0, 1);
		rd_array(9'h0f0, 2);
		wr_array(9'h0f8, 20);
		rd_array(9'h0f0, 16);
		// reset with select held low: that first frame must be ignored
		rstn = 1'b0;
		u_master.open_frame();
		repeat (5) @(negedge clk);
		rstn = 1'b1;
		u_master.shift(8, SEP_OP_SET_LATCH, rx);
		u_master.close_frame();
		latch = 0;
		lockSel = 0;
		dogSel = 0;
		st_check();
		check({6'h00, dogPeriod}, 8'h00, "period reset");
		close_out();
	end
endmodule : spi_eeprom_command_port_bench

// File: verilog/sep_fifo.sv
// Purpose: small parameterised fifo for received write bytes
// Assumes: single clock, synchronous active-low reset
// Notes: drain side may stall; full drops in_ready
`timescale 1ns/10ps
module sep_fifo #(
	parameter int WIDTH = 8,
	parameter int DEPTH = 8
) (
	input  wire logic             clk,
	input  wire logic             rstn,
	input  wire logic             flush,
	input  wire logic [WIDTH-1:0] inData,
	input  wire logic             inValid,
	output logic                  inReady,
	output logic      [WIDTH-1:0] outData,
	output logic                  outValid,
	input  wire logic             outReady
);
	localparam int AW = $clog2(DEPTH);
	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW-1:0]    wrPtr;
	logic [AW-1:0]    rdPtr;
	logic [AW:0]      count;
	logic             doPush;
	logic             doPop;

	assign inReady  = (count != (AW+1)'(DEPTH));
	assign outValid = (count != '0);
	assign doPush   = inValid && inReady;
	assign doPop    = outValid && outReady;
	assign outData  = mem[rdPtr];

	always_ff @(posedge clk)
	begin
		if (doPush)
			mem[wrPtr] <= inData;
	end

	always_ff @(posedge clk)
	begin
		if (!rstn || flush)
		begin
			wrPtr <= '0;
			rdPtr <= '0;
			count <= '0;
		end
		else
		begin
			if (doPush)
				wrPtr <= (wrPtr == AW'(DEPTH-1)) ? '0 : wrPtr + 1'b1;
			if (doPop)
				rdPtr <= (rdPtr == AW'(DEPTH-1)) ? '0 : rdPtr + 1'b1;
			count <= count + (AW+1)'(doPush) - (AW+1)'(doPop);
		end
	end
endmodule : sep_fifo

// File: verilog/sep_pkg.sv
// Purpose: constants for the serial eeprom command port
// Assumes: system clock of 20 MHz sampling the serial link pins
// Notes: status layout and opcodes shared by design and bench
// Notes on behaviour
// - opcodes, addresses and data move most significant bit first both ways
// - input bits taken on serial clock rising edges after select falls
// - output bits change on serial clock falling edges
// - halted serial clock keeps all transfer state; resumes where it stopped
// - opcode 06h sets the write latch
// - opcode 04h clears the write latch
// - opcode 05h reads status; opcode 01h writes watchdog and lock bits
// - read opcode low bits 011, bit 3 is ninth address bit, then address
// - write opcode low bits 010, bit 3 ninth address bit, address, 1-16 bytes
// - latch clears at reset, when a valid write cycle starts, and when protect low
// - latch set, clear and status read take no address or data
// - status reads 0,0,watchdog[1:0],lock[1:0],latch,busy; resets to 00h
// - busy bit reads 1 during an internal write, else 0
// - lock 00 none, 01 180h-1FFh, 10 100h-1FFh, 11 all; reads still allowed
// - watchdog select 00 1.4 s, 01 600 ms, 10 200 ms, 11 off
// - status read served at any time, even while busy
// - write opcode ignored unless a deselect followed the latch set frame
// - latch clear or protect low blocks all writes; both high allows unprotected
// - array read streams successive addresses, wraps to 000, ends on deselect
// - page write wraps low four address bits within a 16-byte page
// - write starts only if select rises right after a complete data byte
// - no command accepted until select has been seen falling after reset
// - protect falling while selected cancels the pending write; not once started
package sep_pkg;
	localparam logic [7:0] SEP_OP_SET_LATCH   = 8'h06;
	localparam logic [7:0] SEP_OP_CLR_LATCH   = 8'h04;
	localparam logic [7:0] SEP_OP_READ_STATUS = 8'h05;
	localparam logic [7:0] SEP_OP_WRITE_STAT  = 8'h01;
	localparam logic [2:0] SEP_OP_READ_LOW    = 3'h3;
	localparam logic [2:0] SEP_OP_WRITE_LOW   = 3'h2;
	localparam int         SEP_ADDR_HI_POS    = 3;
	localparam logic [7:0] SEP_STATUS_RESET   = 8'h00;
	localparam int         SEP_BUSY_POS       = 0;
	localparam int         SEP_LATCH_POS      = 1;
	localparam int         SEP_LOCK_POS       = 2;
	localparam int         SEP_DOG_POS        = 4;
	localparam logic [8:0] SEP_LOCK_QUARTER   = 9'h180;
	localparam logic [8:0] SEP_LOCK_HALF      = 9'h100;
	localparam int         SEP_DEPTH          = 512;
	localparam int         SEP_PAGE_BYTES     = 16;
	localparam int         SEP_FIFO_DEPTH     = 8;
	localparam int         SEP_CLK_MHZ        = 20;
	localparam int         SEP_WRITE_TIME_US  = 5000;
	localparam int         SEP_WRITE_CYCLES   = SEP_WRITE_TIME_US * SEP_CLK_MHZ;
	typedef enum logic [2:0] {SEP_IDLE, SEP_OPCODE, SEP_ADDR, SEP_RDATA, SEP_WDATA, SEP_WSTAT, SEP_IGNORE} sep_state_type;
endpackage : sep_pkg

// File: verilog/sep_port.sv
// Purpose: serial eeprom command port with status and page writes
// Assumes: link pins sampled by clk; serial clock well below clk/4
// Notes: internal write length is a parameter for short simulation
`timescale 1ns/10ps
module sep_port
	import sep_pkg::*;
#(
	parameter int WRITE_CYCLES = SEP_WRITE_CYCLES
) (
	input  wire logic       clk,
	input  wire logic       rstn,
	input  wire logic       selectN,
	input  wire logic       serialClk,
	input  wire logic       serialIn,
	input  wire logic       writeProtectN,
	output logic            serialOut,
	output logic            serialOutEn,
	output logic [1:0]      dogPeriod,
	output logic            busyWriting
);
	// pin synchronisers
	logic [1:0] selSync;
	logic [1:0] sckSync;
	logic [1:0] sdiSync;
	logic [1:0] wpSync;
	logic       sckLast;
	logic       selLast;
	logic       wpLast;

	always_ff @(posedge clk)
	begin
		if (!rstn)
		begin
			// select history starts low: a pin held low at release shows no false fall
			selSync <= 2'h0;
			sckSync <= 2'h0;
			sdiSync <= 2'h0;
			wpSync  <= 2'h0;
			sckLast <= 1'b0;
			selLast <= 1'b0;
			wpLast  <= 1'b0;
		end
		else
		begin
			selSync <= {selSync[0], selectN};
			sckSync <= {sckSync[0], serialClk};
			sdiSync <= {sdiSync[0], serialIn};
			wpSync  <= {wpSync[0], writeProtectN};
			sckLast <= sckSync[1];
			selLast <= selSync[1];
			wpLast  <= wpSync[1];
		end
	end

	logic selected;
	logic sckRise;
	logic sckFall;
	logic selFall;
	logic selRise;
	logic wpFall;
	assign selected = !selSync[1];
	assign sckRise  = selected && sckSync[1] && !sckLast;
	assign sckFall  = selected && !sckSync[1] && sckLast;
	assign selFall  = !selSync[1] && selLast;
	assign selRise  = selSync[1] && !selLast;
	assign wpFall   = !wpSync[1] && wpLast;

	// storage and status
	logic [7:0]    mem [SEP_DEPTH];
	logic [1:0]    lockSel;
	logic          latch;
	logic          armed;
	logic          latchFresh;
	logic [31:0]   busyCount;
	sep_state_type state;
	logic [7:0]    shiftIn;
	logic [2:0]    bitCount;
	logic [7:0]    opcode;
	logic [8:0]    addr;
	logic [7:0]    shiftOut;
	logic          byteDone;
	logic          wrGo;
	logic          wrPending;
	logic          wrCancel;
	logic [8:0]    wrAddr;
	logic [7:0]    newStatus;
	logic [7:0]    pageBuf [SEP_PAGE_BYTES];
	logic [15:0]   pageMask;
	logic [3:0]    fillPtr;
	logic          fifoPush;
	logic          statPending;
	logic          fifoInReady;
	logic [7:0]    fifoData;
	logic          fifoValid;
	logic          fifoPop;
	logic [7:0]    statusValue;
	logic [7:0]    nextByte;
	logic          writeAllowed;

	assign busyWriting = (busyCount != 32'h0000_0000);
	assign statusValue = {2'b00, dogPeriod, lockSel, latch, busyWriting};
	assign nextByte    = {shiftIn[6:0], sdiSync[1]};
	assign byteDone    = sckRise && (bitCount == 3'h7);
	assign writeAllowed = latch && wpSync[1] && !busyWriting && !latchFresh;

	function automatic logic locked(input logic [8:0] a, input logic [1:0] sel);
		case (sel)
			2'b01:   locked = (a >= SEP_LOCK_QUARTER);
			2'b10:   locked = (a >= SEP_LOCK_HALF);
			2'b11:   locked = 1'b1;
			default: locked = 1'b0;
		endcase
	endfunction : locked

	// a high select level must be seen before a fall opens a frame
	always_ff @(posedge clk)
	begin
		if (!rstn)
			armed <= 1'b0;
		else if (selRise)
			armed <= 1'b1;
	end

	// command decoder; all state holds between serial edges
	always_ff @(posedge clk)
	begin
		if (!rstn || !selected)
		begin
			state    <= SEP_IDLE;
			bitCount <= 3'h0;
			shiftIn  <= 8'h00;
		end
		else if (selFall)
		begin
			state    <= armed ? SEP_OPCODE : SEP_IDLE;
			bitCount <= 3'h0;
		end
		else if (sckRise)
		begin
			shiftIn  <= nextByte;
			bitCount <= bitCount + 3'h1;
			if (bitCount == 3'h7)
			begin
				case (state)
					SEP_OPCODE:
					begin
						if (nextByte[2:0] == SEP_OP_READ_LOW || nextByte[2:0] == SEP_OP_WRITE_LOW)
							state <= SEP_ADDR;
						else if (nextByte == SEP_OP_WRITE_STAT)
							state <= SEP_WSTAT;
						else
							state <= SEP_IGNORE;
					end
					SEP_ADDR:
						state <= (opcode[2:0] == SEP_OP_READ_LOW) ? SEP_RDATA : SEP_WDATA;
					default:
						state <= state;
				endcase
			end
		end
	end

	always_ff @(posedge clk)
	begin
		if (!rstn)
			opcode <= 8'h00;
		else if (byteDone && state == SEP_OPCODE)
			opcode <= nextByte;
	end

	// address counter: full wrap on read, page wrap on write
	always_ff @(posedge clk)
	begin
		if (!rstn)
			addr <= 9'h000;
		else if (byteDone && state == SEP_ADDR)
			addr <= {opcode[SEP_ADDR_HI_POS], nextByte};
		else if (byteDone && state == SEP_WDATA)
			addr <= {addr[8:4], addr[3:0] + 4'h1};
		else if (sckFall && state == SEP_RDATA && bitCount == 3'h0)
			addr <= addr + 9'h001;
	end

	// output shifter loads on the falling edge closing a byte
	always_ff @(posedge clk)
	begin
		if (!rstn || !selected)
			shiftOut <= 8'h00;
		else if (sckFall && bitCount == 3'h0)
		begin
			if (state == SEP_RDATA)
				shiftOut <= mem[addr];
			else if (state == SEP_IGNORE && opcode == SEP_OP_READ_STATUS)
				shiftOut <= statusValue;
			else
				shiftOut <= 8'h00;
		end
		else if (sckFall)
			shiftOut <= {shiftOut[6:0], 1'b0};
	end

	always_ff @(posedge clk)
	begin
		if (!rstn)
		begin
			serialOut   <= 1'b0;
			serialOutEn <= 1'b0;
		end
		else
		begin
			serialOut   <= (sckFall && bitCount == 3'h0) ?
			               (state == SEP_RDATA ? mem[addr][7] : statusValue[7]) :
			               (sckFall ? shiftOut[6] : serialOut);
			serialOutEn <= selected && (state == SEP_RDATA ||
			               (state == SEP_IGNORE && opcode == SEP_OP_READ_STATUS));
		end
	end

	// pending write bookkeeping; bytes queue in the fifo
	assign wrGo = selRise && wrPending && bitCount == 3'h0 && !wrCancel;

	always_ff @(posedge clk)
	begin
		if (!rstn)
		begin
			wrPending   <= 1'b0;
			statPending <= 1'b0;
			wrCancel    <= 1'b0;
		end
		else
		begin
			if (selFall)
			begin
				wrPending   <= 1'b0;
				statPending <= 1'b0;
			end
			else
			begin
				if (byteDone && (state == SEP_WDATA || state == SEP_WSTAT) && writeAllowed)
					wrPending <= 1'b1;
				if (byteDone && state == SEP_WSTAT && writeAllowed)
					statPending <= 1'b1;
			end
			if (byteDone && state == SEP_WSTAT)
				newStatus <= nextByte;
			// set wins: a protect drop at the opening fall still cancels
			if (selected && wpFall)
				wrCancel <= 1'b1;
			else if (selFall)
				wrCancel <= 1'b0;
		end
	end

	// refused bytes never queue, so a running commit keeps its page buffer
	assign fifoPush = byteDone && state == SEP_WDATA && writeAllowed;

	sep_fifo #(
		.WIDTH (8),
		.DEPTH (SEP_FIFO_DEPTH)
	) u_fifo (
		.clk      (clk),
		.rstn     (rstn),
		.flush    (selFall),
		.inData   (nextByte),
		.inValid  (fifoPush),
		.inReady  (fifoInReady),
		.outData  (fifoData),
		.outValid (fifoValid),
		.outReady (fifoPop)
	);

	// fifo drains at once into a page buffer, so a full page fits behind 8 words
	logic wrActive;
	assign fifoPop = fifoValid;

	always_ff @(posedge clk)
	begin
		if (!rstn)
		begin
			fillPtr  <= 4'h0;
			pageMask <= 16'h0000;
		end
		else if (wrActive && wrAddr[3:0] == 4'hf)
			pageMask <= 16'h0000;
		else if (selFall && !wrActive)
			pageMask <= 16'h0000;
		else if (byteDone && state == SEP_ADDR)
			fillPtr <= nextByte[3:0];
		else if (fifoPop)
		begin
			pageBuf[fillPtr]  <= fifoData;
			pageMask[fillPtr] <= 1'b1;
			fillPtr           <= fillPtr + 4'h1;
		end
	end

	// commit walks one page slot per clock; busy must outlast 16 cycles
	always_ff @(posedge clk)
	begin
		if (!rstn)
		begin
			wrActive <= 1'b0;
			wrAddr   <= 9'h000;
		end
		else if (wrGo && !statPending)
		begin
			wrActive <= 1'b1;
			wrAddr   <= {addr[8:4], 4'h0};
		end
		else if (wrActive)
		begin
			if (pageMask[wrAddr[3:0]] && !locked(wrAddr, lockSel))
				mem[wrAddr] <= pageBuf[wrAddr[3:0]];
			wrAddr <= {wrAddr[8:4], wrAddr[3:0] + 4'h1};
			if (wrAddr[3:0] == 4'hf)
				wrActive <= 1'b0;
		end
	end

	always_ff @(posedge clk)
	begin
		if (!rstn)
			busyCount <= 32'h0000_0000;
		else if (wrGo)
			busyCount <= 32'(WRITE_CYCLES);
		else if (busyCount != 32'h0000_0000)
			busyCount <= busyCount - 32'h0000_0001;
	end

	always_ff @(posedge clk)
	begin
		if (!rstn)
		begin
			dogPeriod <= SEP_STATUS_RESET[SEP_DOG_POS +: 2];
			lockSel   <= SEP_STATUS_RESET[SEP_LOCK_POS +: 2];
		end
		else if (wrGo && statPending)
		begin
			dogPeriod <= newStatus[SEP_DOG_POS +: 2];
			lockSel   <= newStatus[SEP_LOCK_POS +: 2];
		end
	end

	// write latch; set at once, but allows writes only once a deselect follows it
	always_ff @(posedge clk)
	begin
		if (!rstn)
		begin
			latch      <= 1'b0;
			latchFresh <= 1'b0;
		end
		else if (!wpSync[1] || wrGo)
		begin
			latch      <= 1'b0;
			latchFresh <= 1'b0;
		end
		else if (byteDone && state == SEP_OPCODE && nextByte == SEP_OP_SET_LATCH)
		begin
			latch      <= 1'b1;
			latchFresh <= 1'b1;
		end
		else if (byteDone && state == SEP_OPCODE && nextByte == SEP_OP_CLR_LATCH)
			latch <= 1'b0;
		else if (selRise)
			latchFresh <= 1'b0;
	end

	AST_BUSY_AFTER_GO: assert property (@(posedge clk) disable iff (!rstn) wrGo |=> busyWriting)
		else $error("busy not set after write start");
	AST_LATCH_CLEARED: assert property (@(posedge clk) disable iff (!rstn) wrGo |=> !latch)
		else $error("latch not cleared after write");
	AST_WP_CLEARS: assert property (@(posedge clk) disable iff (!rstn) !wpSync[1] |=> !latch)
		else $error("latch held while protect low");
	AST_NO_WRITE_WHEN_BUSY: assert property (@(posedge clk) disable iff (!rstn) busyWriting && $past(busyWriting) |-> !wrGo || !wrPending)
		else $error("write accepted while busy");
	AST_STATUS_TOP: assert property (@(posedge clk) disable iff (!rstn)
		sckFall && bitCount == 3'h0 && state == SEP_IGNORE && opcode == SEP_OP_READ_STATUS |=> shiftOut[7:6] == 2'b00)
		else $error("status top bits not zero");
	AST_SET_LATCH: assert property (@(posedge clk) disable iff (!rstn)
		byteDone && state == SEP_OPCODE && nextByte == SEP_OP_SET_LATCH && wpSync[1] |=> latch)
		else $error("latch not set");
	AST_OE_IDLE: assert property (@(posedge clk) disable iff (!rstn) !selected |=> !serialOutEn)
		else $error("output driven while deselected");
	AST_NOT_ARMED: assert property (@(posedge clk) disable iff (!rstn) !armed |-> !wrPending)
		else $error("write pending before first select");
	AST_FIFO_ROOM: assert property (@(posedge clk) disable iff (!rstn) fifoPush |-> fifoInReady)
		else $error("write byte pushed into a full queue");
	AST_COMMIT_IN_BUSY: assert property (@(posedge clk) disable iff (!rstn) wrActive |-> busyWriting)
		else $error("page commit outside the busy cycle");
endmodule : sep_port
